// >>> rtl/pfbo_defs.vh
// Timing and pin-code constants for the parallel flash bus host controller
`ifndef PFBO_DEFS_VH
`define PFBO_DEFS_VH

// ****************************************************************
// Clock
// ****************************************************************
`define PFBO_CLK_PERIOD_NS        20

// ****************************************************************
// Device timing figures in ns
// ****************************************************************
`define PFBO_ADDR_ACCESS_NS       70
`define PFBO_CE_ACCESS_NS         70
`define PFBO_WR_PULSE_NS          35
`define PFBO_WR_HOLD_NS           20
`define PFBO_RESET_PULSE_MIN_NS   500
`define PFBO_RESET_TO_READ_NS     50
`define PFBO_READY_MAX_NS         20000

// ****************************************************************
// Cycle counts, least times rounded up
// ****************************************************************
`define PFBO_CYC_UP(ns)  (((ns) + `PFBO_CLK_PERIOD_NS - 1) / `PFBO_CLK_PERIOD_NS)
`define PFBO_ACC_CYC     `PFBO_CYC_UP(`PFBO_CE_ACCESS_NS)
`define PFBO_WRP_CYC     `PFBO_CYC_UP(`PFBO_WR_PULSE_NS)
`define PFBO_WRH_CYC     `PFBO_CYC_UP(`PFBO_WR_HOLD_NS)
`define PFBO_RP_CYC      `PFBO_CYC_UP(`PFBO_RESET_PULSE_MIN_NS)
`define PFBO_RH_CYC      `PFBO_CYC_UP(`PFBO_RESET_TO_READ_NS)
`define PFBO_RDY_CYC     `PFBO_CYC_UP(`PFBO_READY_MAX_NS)

// ****************************************************************
// Command codes on the user port
// ****************************************************************
`define PFBO_OP_READ       3'h0
`define PFBO_OP_WRITE      3'h1
`define PFBO_OP_PROTECT    3'h2
`define PFBO_OP_UNPROTECT  3'h3
`define PFBO_OP_RESET      3'h4

// ****************************************************************
// Address bit positions for protect cycles
// ****************************************************************
`define PFBO_PROT_A6       6
`define PFBO_PROT_A1       1
`define PFBO_PROT_A0       0

`endif

// >>> rtl/pfbo_host.v
// Host controller that drives a parallel NOR flash through its bus pins
`timescale 1ns/1ps
`include "pfbo_defs.vh"

module pfbo_host (
   input  wire        ref_clk,
   input  wire        arst_n,
   input  wire        req_valid,
   output wire        req_ready,
   input  wire [2:0]  req_op,
   input  wire [20:0] req_addr,
   input  wire [15:0] req_wdata,
   input  wire        word_mode,
   output reg         rsp_valid_r,
   output reg  [15:0] rsp_rdata_r,
   output reg         reset_recovered_r,
   output reg  [19:0] flash_addr_r,
   output reg         flash_ce_n_r,
   output reg         flash_oe_n_r,
   output reg         flash_we_n_r,
   output reg         flash_reset_n_r,
   output reg         flash_hv_select_r,
   output reg         flash_width_word_r,
   input  wire [15:0] dq_in,
   output reg  [15:0] dq_out_r,
   output reg  [15:0] dq_oe_r,
   input  wire        completion_pin
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam ST_IDLE   = 3'h0;
   localparam ST_READ   = 3'h1;
   localparam ST_WRITE  = 3'h2;
   localparam ST_WHOLD  = 3'h3;
   localparam ST_RSTLOW = 3'h4;
   localparam ST_RSTREC = 3'h5;
   localparam ST_RDYWT  = 3'h6;

   localparam integer ACC_I   = `PFBO_ACC_CYC;
   localparam integer WRP_I   = `PFBO_WRP_CYC;
   localparam integer WRH_I   = `PFBO_WRH_CYC;
   localparam integer RP_I    = `PFBO_RP_CYC;
   localparam integer RH_I    = `PFBO_RH_CYC;
   localparam integer RDY_I   = `PFBO_RDY_CYC;
   localparam [15:0]  ACC_CYC = ACC_I[15:0];
   localparam [15:0]  WRP_CYC = WRP_I[15:0];
   localparam [15:0]  WRH_CYC = WRH_I[15:0];
   localparam [15:0]  RP_CYC  = RP_I[15:0];
   localparam [15:0]  RH_CYC  = RH_I[15:0];
   localparam [15:0]  RDY_CYC = RDY_I[15:0];

   reg [2:0]  state_r;
   reg [2:0]  state_nxt;
   reg [15:0] cnt_r;
   reg [15:0] cnt_nxt;

   wire [15:0] byte_lane_oe;
   wire [19:0] cmd_addr;
   wire        cnt_done;

   assign req_ready = (state_r == ST_IDLE);
   assign cnt_done  = (cnt_r == 16'h0001) || (cnt_r == 16'h0000);

   // ****************************************************************
   // Address and lane mapping
   // ****************************************************************
   assign cmd_addr = word_mode ? req_addr[19:0] : req_addr[20:1];
   // Pin 15 carries the low address bit in byte width, never data
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_lane
         if (gi < 8) begin : g_lo
            assign byte_lane_oe[gi] = 1'b1;
         end else if (gi < 15) begin : g_mid
            assign byte_lane_oe[gi] = word_mode;
         end else begin : g_top
            assign byte_lane_oe[gi] = 1'b1;
         end
      end
   endgenerate

   // ****************************************************************
   // Next state
   // ****************************************************************
   always @* begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
      case (state_r)
         ST_IDLE: begin
            if (req_valid) begin
               case (req_op)
                  `PFBO_OP_READ: begin
                     state_nxt = ST_READ;
                     cnt_nxt   = ACC_CYC;
                  end
                  `PFBO_OP_WRITE, `PFBO_OP_PROTECT, `PFBO_OP_UNPROTECT: begin
                     state_nxt = ST_WRITE;
                     cnt_nxt   = WRP_CYC;
                  end
                  `PFBO_OP_RESET: begin
                     state_nxt = ST_RSTLOW;
                     cnt_nxt   = RP_CYC;
                  end
                  default: begin
                     state_nxt = ST_IDLE;
                  end
               endcase
            end
         end
         ST_READ: begin
            if (cnt_done) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (cnt_done) begin
               state_nxt = ST_WHOLD;
               cnt_nxt   = WRH_CYC;
            end
         end
         ST_WHOLD: begin
            if (cnt_done) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RSTLOW: begin
            if (cnt_done) begin
               state_nxt = ST_RDYWT;
               cnt_nxt   = RDY_CYC;
            end
         end
         ST_RDYWT: begin
            // Busy device finishes its internal reset first
            if (completion_pin || cnt_done) begin
               state_nxt = ST_RSTREC;
               cnt_nxt   = RH_CYC;
            end
         end
         ST_RSTREC: begin
            if (cnt_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // Registers and pins
   // ****************************************************************
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r            <= ST_IDLE;
         cnt_r              <= 16'h0000;
         rsp_valid_r        <= 1'b0;
         rsp_rdata_r        <= 16'h0000;
         reset_recovered_r  <= 1'b0;
         flash_addr_r       <= 20'h00000;
         flash_ce_n_r       <= 1'b1;
         flash_oe_n_r       <= 1'b1;
         flash_we_n_r       <= 1'b1;
         flash_reset_n_r    <= 1'b1;
         flash_hv_select_r  <= 1'b0;
         flash_width_word_r <= 1'b1;
         dq_out_r           <= 16'h0000;
         dq_oe_r            <= 16'h0000;
      end else begin
         state_r            <= state_nxt;
         cnt_r              <= cnt_nxt;
         rsp_valid_r        <= 1'b0;
         reset_recovered_r  <= 1'b0;
         if (state_r == ST_IDLE && req_valid) begin
            // Width is held for the whole cycle, not followed live
            flash_width_word_r <= word_mode;
            flash_addr_r <= cmd_addr;
            dq_out_r     <= word_mode ? req_wdata : {req_addr[0], 7'h00, req_wdata[7:0]};
            case (req_op)
               `PFBO_OP_READ: begin
                  flash_ce_n_r <= 1'b0;
                  flash_oe_n_r <= 1'b0;
                  flash_we_n_r <= 1'b1;
                  dq_oe_r      <= word_mode ? 16'h0000 : 16'h8000;
               end
               `PFBO_OP_WRITE, `PFBO_OP_PROTECT, `PFBO_OP_UNPROTECT: begin
                  flash_ce_n_r <= 1'b0;
                  flash_oe_n_r <= 1'b1;
                  flash_we_n_r <= 1'b0;
                  dq_oe_r      <= byte_lane_oe;
                  if (req_op != `PFBO_OP_WRITE) begin
                     flash_hv_select_r <= 1'b1;
                     flash_addr_r[`PFBO_PROT_A6] <= (req_op == `PFBO_OP_UNPROTECT);
                     flash_addr_r[`PFBO_PROT_A1] <= 1'b1;
                     flash_addr_r[`PFBO_PROT_A0] <= 1'b0;
                  end
               end
               `PFBO_OP_RESET: begin
                  flash_reset_n_r <= 1'b0;
                  flash_ce_n_r    <= 1'b1;
                  flash_oe_n_r    <= 1'b1;
                  flash_we_n_r    <= 1'b1;
                  dq_oe_r         <= 16'h0000;
               end
               default: begin
                  flash_ce_n_r <= 1'b1;
               end
            endcase
         end
         if (state_r == ST_READ && cnt_done) begin
            rsp_valid_r  <= 1'b1;
            rsp_rdata_r  <= flash_width_word_r ? dq_in : {8'h00, dq_in[7:0]};
            flash_ce_n_r <= 1'b1;
            flash_oe_n_r <= 1'b1;
            dq_oe_r      <= 16'h0000;
         end
         if (state_r == ST_WRITE && cnt_done) begin
            flash_we_n_r <= 1'b1;
         end
         if (state_r == ST_WHOLD && cnt_done) begin
            flash_ce_n_r      <= 1'b1;
            flash_hv_select_r <= 1'b0;
            dq_oe_r           <= 16'h0000;
         end
         if (state_r == ST_RSTLOW && cnt_done) begin
            flash_reset_n_r <= 1'b1;
         end
         if (state_r == ST_RSTREC && cnt_done) begin
            reset_recovered_r <= 1'b1;
         end
      end
   end

endmodule

// >>> test/pfbo_flash_model.sv
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
module pfbo_flash_model #(parameter int BUSY_NS = 2000) (
   input  wire logic [19:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        reset_n,
   input  wire logic        hv,
   input  wire logic        width_word,
   input  wire logic [15:0] host_dq,
   input  wire logic [15:0] host_oe,
   output logic      [15:0] dq,
   output logic             rdy = 1'h1
);
   logic [15:0] mem [0:255];
   logic [15:0] rd;
   logic        flt = 1'h0;
   time         done_t = 0;
   wire         drv = !ce_n && !oe_n && we_n && reset_n;
   wire  [7:0]  wa = addr[7:0];
   initial for (int i = 0; i < 256; i++) mem[i] = {i[7:0] ^ 8'h3C, i[7:0]};
   // Released pins toggle so a stale value never reads as valid
   always #7 flt = ~flt;
   always @* begin
      rd = width_word ? mem[wa] : {8'h00, host_dq[15] ? mem[wa][15:8] : mem[wa][7:0]};
      for (int i = 0; i < 16; i++)
         dq[i] = host_oe[i] ? host_dq[i] : (drv && (width_word || i < 8)) ? rd[i] : flt ^ i[0];
   end
   always @(posedge we_n) if (!ce_n && oe_n && reset_n && !hv) begin
      if (width_word) mem[wa] = host_dq;
      else if (host_dq[15]) mem[wa][15:8] = host_dq[7:0];
      else mem[wa][7:0] = host_dq[7:0];
      done_t = $time + BUSY_NS;
   end
   // Busy runs on through deselect and reset
   always #5 rdy = ($time >= done_t);
endmodule

// >>> test/pfbo_host_sva.sv
// Concurrent checks on the flash host controller ports
`timescale 1ns/1ps
`include "pfbo_defs.vh"
module pfbo_host_sva (
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [2:0]  req_op,
   input wire logic        rsp_valid_r,
   input wire logic [19:0] flash_addr_r,
   input wire logic        flash_ce_n_r,
   input wire logic        flash_oe_n_r,
   input wire logic        flash_we_n_r,
   input wire logic        flash_reset_n_r,
   input wire logic        flash_hv_select_r,
   input wire logic        flash_width_word_r,
   input wire logic [15:0] dq_oe_r
);
   logic [7:0] low_cnt_r;
   logic [7:0] hi_cnt_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt_r <= 8'h00;
         hi_cnt_r <= 8'hFF;
      end else begin
         low_cnt_r <= flash_reset_n_r ? 8'h00 : low_cnt_r + {7'h00, low_cnt_r != 8'hFF};
         hi_cnt_r <= !flash_reset_n_r ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hFF};
      end
   end
   sequence take(logic [2:0] op);
      req_valid && req_ready && req_op == op;
   endsequence
   sequence prot_cyc;
      flash_hv_select_r && flash_addr_r[1] && !flash_addr_r[0] && !flash_ce_n_r && !flash_we_n_r && flash_oe_n_r;
   endsequence
   rd_pins_a: assert property (take(`PFBO_OP_READ) |=> !flash_ce_n_r && !flash_oe_n_r && flash_we_n_r
      && flash_reset_n_r) else $error("read cycle pin levels wrong");
   rd_answer_a: assert property (take(`PFBO_OP_READ) |-> ##[5:6] rsp_valid_r) else $error("read answer late");
   wr_pins_a: assert property (take(`PFBO_OP_WRITE) |=> !flash_ce_n_r && !flash_we_n_r && flash_oe_n_r)
      else $error("write cycle pin levels wrong");
   no_clash_a: assert property (!flash_oe_n_r |-> dq_oe_r == (flash_width_word_r ? 16'h0000 : 16'h8000))
      else $error("host drives data while output gate low");
   prot_pins_a: assert property (take(`PFBO_OP_PROTECT) |=> prot_cyc ##0 !flash_addr_r[6])
      else $error("protect cycle wrong");
   unprot_pins_a: assert property (take(`PFBO_OP_UNPROTECT) |=> prot_cyc ##0 flash_addr_r[6])
      else $error("unprotect cycle wrong");
   rst_len_a: assert property ($rose(flash_reset_n_r) |-> low_cnt_r >= 8'h19) else $error("reset pulse short");
   rh_gap_a: assert property ($fell(flash_oe_n_r) |-> hi_cnt_r >= 8'h03) else $error("read too soon after reset");
   rst_quiet_a: assert property (!flash_reset_n_r |-> flash_ce_n_r && flash_oe_n_r && flash_we_n_r
      && dq_oe_r == 16'h0000) else $error("bus active during reset pulse");
endmodule
bind pfbo_host pfbo_host_sva chk (.*);

// >>> test/pfbo_host_bench.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "pfbo_defs.vh"
module pfbo_host_bench;
   logic        ref_clk = 1'h0, arst_n = 1'h0, req_valid = 1'h0, word_mode = 1'h1;
   logic [2:0]  req_op = 3'h0;
   logic [20:0] req_addr = 21'h000000;
   logic [15:0] req_wdata = 16'h0000;
   wire         req_ready, rsp_valid_r, reset_recovered_r, flash_ce_n_r, flash_oe_n_r, flash_we_n_r;
   wire         flash_reset_n_r, flash_hv_select_r, flash_width_word_r, completion_pin;
   wire  [15:0] rsp_rdata_r, dq_in, dq_out_r, dq_oe_r;
   wire  [19:0] flash_addr_r;
   int          error_cnt = 0, compares = 0;
   always #10 ref_clk = ~ref_clk;
   pfbo_host uut (.*);
   pfbo_flash_model dev (.addr(flash_addr_r), .ce_n(flash_ce_n_r), .oe_n(flash_oe_n_r), .we_n(flash_we_n_r),
      .reset_n(flash_reset_n_r), .hv(flash_hv_select_r), .width_word(flash_width_word_r), .host_dq(dq_out_r),
      .host_oe(dq_oe_r), .dq(dq_in), .rdy(completion_pin));
   function automatic logic [15:0] pre(input int i);
      return {i[7:0] ^ 8'h3C, i[7:0]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic req(input logic [2:0] op, input logic [20:0] a, input logic [15:0] d, input logic wm);
      int n = 0;
      @(posedge ref_clk);
      req_valid <= 1'h1;
      req_op <= op;
      req_addr <= a;
      req_wdata <= d;
      word_mode <= wm;
      @(negedge ref_clk);
      while (req_ready !== 1'h1 && n++ < 3000) @(negedge ref_clk);
      chk({15'h0000, req_ready}, 16'h0001, "request taken");
      @(posedge ref_clk);
      req_valid <= 1'h0;
   endtask
   task automatic rd(input logic [20:0] a, input logic wm, input logic [15:0] exp);
      int n = 0;
      req(`PFBO_OP_READ, a, 16'h0000, wm);
      @(negedge ref_clk);
      while (rsp_valid_r !== 1'h1 && n++ < 12) @(negedge ref_clk);
      chk({15'h0000, rsp_valid_r}, 16'h0001, "read answer");
      chk(rsp_rdata_r, exp, "read data");
   endtask
   task automatic wait_sig(input int which);
      int n = 0;
      while ((which ? reset_recovered_r : completion_pin) !== 1'h1 && n++ < 2000) @(negedge ref_clk);
      chk({15'h0000, which ? reset_recovered_r : completion_pin}, 16'h0001, "wait limit");
   endtask
   task automatic t_array;
      rd(21'h000012, 1'h1, pre(18));
      rd(21'h0000FF, 1'h1, pre(255));
      $display("array read test done");
   endtask
   task automatic t_write;
      req(`PFBO_OP_WRITE, 21'h000040, 16'hBEEF, 1'h1);
      req(`PFBO_OP_WRITE, 21'h000041, 16'h0F0F, 1'h1);
      wait_sig(0);
      rd(21'h000040, 1'h1, 16'hBEEF);
      rd(21'h000041, 1'h1, 16'h0F0F);
      rd(21'h000042, 1'h1, pre(66));
      $display("write test done");
   endtask
   task automatic t_byte;
      rd(21'h000024, 1'h0, pre(18) & 16'h00FF);
      rd(21'h000025, 1'h0, pre(18) >> 8);
      req(`PFBO_OP_WRITE, 21'h000051, 16'h00A5, 1'h0);
      wait_sig(0);
      rd(21'h000051, 1'h0, 16'h00A5);
      rd(21'h000050, 1'h0, pre(40) & 16'h00FF);
      rd(21'h000028, 1'h1, {8'hA5, 8'h28});
      $display("byte width test done");
   endtask
   task automatic t_protect;
      req(`PFBO_OP_PROTECT, 21'h000047, 16'h0000, 1'h1);
      req(`PFBO_OP_UNPROTECT, 21'h000007, 16'h0000, 1'h1);
      rd(21'h000006, 1'h1, pre(6));
      rd(21'h000046, 1'h1, pre(70));
      $display("protect test done");
   endtask
   task automatic t_reset;
      req(`PFBO_OP_WRITE, 21'h000060, 16'h1234, 1'h1);
      req(`PFBO_OP_RESET, 21'h000000, 16'h0000, 1'h1);
      wait_sig(1);
      chk({15'h0000, completion_pin}, 16'h0001, "busy at recovery");
      rd(21'h000012, 1'h1, pre(18));
      req(`PFBO_OP_RESET, 21'h000000, 16'h0000, 1'h1);
      wait_sig(1);
      chk({15'h0000, reset_recovered_r}, 16'h0001, "idle recovery");
      rd(21'h000013, 1'h1, pre(19));
      $display("reset test done");
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'h1;
      t_array;
      t_write;
      t_byte;
      t_protect;
      t_reset;
      wrap_up;
   end
   initial begin
      #400000;
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up;
   end
endmodule
